// file: rtl/msf_top.sv
`timescale 1ns/1ps

// Operation
// R1: Only the two selects activate the unit.
// R2: Both translate; one ignores; none floats outputs.
// R3: Two units: decode selects from address 29.
// R4: Four units: decode from addresses 28, 29.
// R5: Only one active unit translates and misses.
// R6: Decode selects exactly one unit for registers.
// R7: Software initialises tables through register accesses.
// R8: Miss fetches descriptor when first needed.
// R9: Table register writes flush the descriptor cache.
// R10: Software avoids base plus offset wraparound.
// R11: Fault stores code and virtual address.
// R12: Translation or descriptor fault drives fault output.
// R13: Descriptor cacheable bit marks the segment.
// R14: Object trap faults every segment access.
// R15: Page-write fault reports writes to shared pages.
// R16: Present, referenced, modified bits; config enables updates.
// R17: Fault registers hold until read or rewritten.
module msf_top import msf_pkg::*; #(
    parameter int IDX_W = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic xlate_select_a,
    input wire logic xlate_select_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic xl_req,
    input wire logic [31:0] xl_vaddr,
    input wire logic xl_write,
    output logic xl_done,
    output logic [31:0] xl_paddr,
    output logic xl_cacheable,
    output logic xl_out_oe_n,
    output logic xlate_fault_out,
    output logic xlate_fault_oe_n,
    output logic desc_req,
    output logic desc_wr,
    output logic [31:0] desc_addr,
    output logic [31:0] desc_wdata,
    input wire logic desc_ack,
    input wire logic [31:0] desc_rdata,
    input wire logic desc_err,
    output logic irq
);

    localparam int ENTRIES = 1 << IDX_W;

    // ****************************************************************
    // Select pins and bus decode.
    // ****************************************************************
    logic [1:0] sel_lvl; // Filtered select levels, b in bit 1.
    logic sel_both; // Unit is selected.
    logic sel_none; // Unit is fully deselected.
    logic wr_ok; // Accepted register write.
    logic rd_ok; // Accepted register read.

    msf_pin_sync #(.WIDTH(2)) u_sel_sync (
        .clk(clk),
        .nrst(nrst),
        .pin({xlate_select_b, xlate_select_a}),
        .level(sel_lvl)
    );

    // The selects alone decide whether the unit responds.
    assign sel_both = sel_lvl[0] & sel_lvl[1]; // see R1
    assign sel_none = ~sel_lvl[0] & ~sel_lvl[1]; // see R2
    // Registers answer only while this unit is the selected one.
    assign wr_ok = reg_wr & sel_both; // see R6
    assign rd_ok = reg_rd & sel_both; // see R6
    // With no select at all, the translation and fault output drivers are released.
    assign xl_out_oe_n = sel_none; // see R2
    assign xlate_fault_oe_n = sel_none; // see R2

    // Decodes a write to one offset.
    function automatic logic wr_at(input logic [7:0] ofs);
        wr_at = wr_ok && (reg_addr == ofs);
    endfunction

    // ****************************************************************
    // Software registers.
    // ****************************************************************
    logic [1:0] config_reg; // Referenced/modified update enables.
    logic [31:0] seg_base_reg; // Segment table base address.
    logic [7:0] seg_len_reg; // Number of segment table entries.
    logic [IDX_W-1:0] pre_idx_reg; // Entry that a preload writes.
    logic [EV_W-1:0] irq_en_reg; // Interrupt enables.
    logic flush; // Table rewrite flushes the cache.

    // Table base and length are written in peripheral mode.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            config_reg <= CONFIG_RST;
            seg_base_reg <= SEG_BASE_RST;
            seg_len_reg <= SEG_LEN_RST;
            pre_idx_reg <= '0;
            irq_en_reg <= '0;
        end else begin
            if (wr_at(OFS_CONFIG)) begin
                config_reg <= reg_wdata[1:0]; // see R16
            end
            if (wr_at(OFS_SEG_BASE)) begin
                seg_base_reg <= reg_wdata; // see R7
            end
            if (wr_at(OFS_SEG_LEN)) begin
                seg_len_reg <= reg_wdata[7:0]; // see R7
            end
            if (wr_at(OFS_PRE_IDX)) begin
                pre_idx_reg <= reg_wdata[IDX_W-1:0];
            end
            if (wr_at(OFS_IRQ_EN)) begin
                irq_en_reg <= reg_wdata[EV_W-1:0];
            end
        end
    end

    // A process switch rewrites the table registers and so flushes.
    assign flush = wr_at(OFS_SEG_BASE) | wr_at(OFS_SEG_LEN);  // see R9

    // ****************************************************************
    // Translation sequencer.
    // ****************************************************************
    msf_state_t state_reg;
    msf_state_t state_next;
    logic [31:0] va_reg; // Virtual address under translation.
    logic wr_acc_reg; // Access under translation is a write.
    logic [IDX_W-1:0] idx; // Segment index of that address.
    logic [31:0] hit_desc; // Cached descriptor for that index.
    logic hit; // Descriptor is cached.
    logic need_upd; // Referenced/modified bits need update.
    logic [7:0] chk_code; // Fault found while checking.
    logic fault_evt; // One-cycle fault event.
    logic [7:0] fault_code; // Code that goes with the event.
    logic fill_evt; // Miss fetch completed.

    logic [31:0] desc_mem [ENTRIES]; // Descriptor cache storage.
    logic [ENTRIES-1:0] desc_vld; // Descriptor cache valid bits.

    assign idx = va_reg[VA_OFS_W +: IDX_W];
    assign hit = desc_vld[idx];
    assign hit_desc = desc_mem[idx];

    // Referenced bit when enabled, modified bit on writes when enabled.
    assign need_upd =
        (config_reg[CFG_REF_BIT] & ~hit_desc[DSC_REF]) |
        (config_reg[CFG_MOD_BIT] & wr_acc_reg & ~hit_desc[DSC_MOD]); // see R16

    // Checks a cached descriptor in priority order.
    always_comb begin
        if (!hit_desc[DSC_PRESENT]) begin
            chk_code = FC_NOT_PRESENT; // see R16
        end else if (hit_desc[DSC_OBJ_TRAP]) begin
            chk_code = FC_OBJ_TRAP; // see R14
        end else if (wr_acc_reg && hit_desc[DSC_WR_FAULT]) begin
            chk_code = FC_PAGE_WRITE; // see R15
        end else begin
            chk_code = FC_NONE;
        end
    end

    // Next state of the sequencer.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                // Only the fully selected unit takes translations.
                if (xl_req && sel_both) begin               // see R5
                    state_next = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (!hit) begin
                    // Entries beyond the table length fault at once.
                    if ({24'h0, 5'h0, idx} >= {24'h0, seg_len_reg}) begin
                        state_next = ST_DONE;
                    end else begin
                        state_next = ST_FETCH;              // see R8
                    end
                end else if (chk_code != FC_NONE) begin
                    state_next = ST_DONE;
                end else if (need_upd) begin
                    state_next = ST_UPDATE;
                end else begin
                    state_next = ST_DONE;
                end
            end
            ST_FETCH: begin
                // A fetched descriptor is checked again from the cache.
                if (desc_ack) begin
                    state_next = desc_err ? ST_DONE : ST_CHECK;
                end
            end
            ST_UPDATE: begin
                if (desc_ack) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Sequencer state register.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Latch the request when it is taken.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            va_reg <= '0;
            wr_acc_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && xl_req && sel_both) begin
            va_reg <= xl_vaddr;
            wr_acc_reg <= xl_write;
        end
    end

    // The descriptor port holds its request until acknowledged.
    assign desc_req = (state_reg == ST_FETCH) | (state_reg == ST_UPDATE);
    assign desc_wr = (state_reg == ST_UPDATE);

    // Descriptor address and write data for miss and bit update.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            desc_addr <= '0;
            desc_wdata <= '0;
        end else if (state_reg == ST_CHECK) begin
            desc_addr <= seg_base_reg + {27'h0, idx, 2'h0};   // see R8
            desc_wdata <= hit_desc | (32'h1 << DSC_REF) |
                (wr_acc_reg ? (32'h1 << DSC_MOD) : 32'h0); // see R16
        end
    end

    // Descriptor cache: preload, miss fill, bit update and flush.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            desc_vld <= '0;
            for (int i = 0; i < ENTRIES; i++) begin
                desc_mem[i] <= '0;
            end
        end else if (flush) begin
            desc_vld <= '0; // see R9
        end else if (wr_at(OFS_PRE_DATA)) begin
            desc_mem[pre_idx_reg] <= reg_wdata; // see R7
            desc_vld[pre_idx_reg] <= 1'b1;
        end else if (state_reg == ST_FETCH && desc_ack && !desc_err) begin
            desc_mem[idx] <= desc_rdata; // see R8
            desc_vld[idx] <= 1'b1;
        end else if (state_reg == ST_UPDATE && desc_ack && !desc_err) begin
            desc_mem[idx] <= desc_wdata; // see R16
        end
    end

    assign fill_evt = (state_reg == ST_FETCH) & desc_ack & ~desc_err;

    // Fault event and its code, one cycle long.
    always_comb begin
        fault_evt = 1'b0;
        fault_code = FC_NONE;
        if (state_reg == ST_CHECK && !hit &&
            {24'h0, 5'h0, idx} >= {24'h0, seg_len_reg}) begin
            fault_evt = 1'b1;
            fault_code = FC_LENGTH;
        end else if (state_reg == ST_CHECK && hit && chk_code != FC_NONE) begin
            fault_evt = 1'b1;
            fault_code = chk_code;
        end else if (desc_req && desc_ack && desc_err) begin
            fault_evt = 1'b1;
            fault_code = FC_MEM;
        end
    end

    // Translation answer, fault pin and cacheable flag.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            xl_done <= 1'b0;
            xl_paddr <= '0;
            xl_cacheable <= 1'b0;
            xlate_fault_out <= 1'b0;
        end else begin
            xl_done <= (state_reg == ST_DONE);
            xlate_fault_out <= 1'b0;
            if (fault_evt) begin
                xlate_fault_out <= 1'b1;                    // see R12
            end
            if (state_reg == ST_CHECK && hit) begin
                // Contiguous segment: base plus offset, may wrap.
                xl_paddr <= {hit_desc[31:DSC_BASE_LSB], 8'h00} +
                    {8'h00, va_reg[VA_OFS_W-1:0]}; // see R10
                xl_cacheable <= hit_desc[DSC_CACHE]; // see R13
            end
        end
    end

    // ****************************************************************
    // Fault capture registers.
    // ****************************************************************
    logic [7:0] fault_code_reg; // Last captured fault code.
    logic [31:0] fault_address_reg; // Last captured virtual address.
    logic fault_held_reg; // Registers hold an unread fault.

    // Capture the first fault; keep it until software reads the fault code or writes either fault register.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fault_code_reg <= FCODE_RST;
            fault_address_reg <= '0;
            fault_held_reg <= 1'b0;
        end else begin
            if (rd_ok && reg_addr == OFS_FCODE) begin
                fault_held_reg <= 1'b0;                     // see R17
            end
            if (wr_at(OFS_FCODE)) begin
                fault_code_reg <= reg_wdata[7:0];
                fault_held_reg <= 1'b0;                     // see R17
            end
            if (wr_at(OFS_FADDR)) begin
                fault_address_reg <= reg_wdata;
                fault_held_reg <= 1'b0;
            end
            if (fault_evt && !fault_held_reg) begin
                fault_code_reg <= fault_code;               // see R11
                fault_address_reg <= va_reg;                // see R11
                fault_held_reg <= 1'b1;                     // see R17
            end
        end
    end

    // ****************************************************************
    // Interrupt events.
    // ****************************************************************
    logic [EV_W-1:0] irq_stat_reg; // Sticky event bits.
    logic [EV_W-1:0] ev_set; // Events of this cycle.

    assign ev_set = {flush, fill_evt, fault_evt};

    // Set wins over a clear in the same cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_reg <= '0;
        end else if (wr_at(OFS_IRQ_CLR)) begin
            irq_stat_reg <= (irq_stat_reg & ~reg_wdata[EV_W-1:0]) | ev_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | ev_set;
        end
    end

    assign irq = |(irq_stat_reg & irq_en_reg);

    // ****************************************************************
    // Register read data, one cycle after the read strobe.
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= '0;
            if (rd_ok) begin
                case (reg_addr)
                    OFS_CONFIG: reg_rdata <= {30'h0, config_reg};
                    OFS_SEG_BASE: reg_rdata <= seg_base_reg;
                    OFS_SEG_LEN: reg_rdata <= {24'h0, seg_len_reg};
                    OFS_FCODE: reg_rdata <= {24'h0, fault_code_reg};
                    OFS_FADDR: reg_rdata <= fault_address_reg;
                    OFS_IRQ_STAT: reg_rdata <= {29'h0, irq_stat_reg};
                    OFS_IRQ_EN: reg_rdata <= {29'h0, irq_en_reg};
                    OFS_PRE_IDX: reg_rdata <= {29'h0, pre_idx_reg};
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

endmodule

// file: rtl/msf_pkg.sv
package msf_pkg;

    // ****************************************************************
    // Register offsets on the plain register port (byte addresses).
    // ****************************************************************
    localparam logic [7:0] OFS_CONFIG = 8'h00; // Update enables.
    localparam logic [7:0] OFS_SEG_BASE = 8'h04; // Segment table base.
    localparam logic [7:0] OFS_SEG_LEN = 8'h08; // Segment table length.
    localparam logic [7:0] OFS_FCODE = 8'h0C; // Fault code.
    localparam logic [7:0] OFS_FADDR = 8'h10; // Fault address.
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14; // Sticky events, RO.
    localparam logic [7:0] OFS_IRQ_CLR = 8'h18; // Event clear, WO.
    localparam logic [7:0] OFS_IRQ_EN = 8'h1C; // Event enables.
    localparam logic [7:0] OFS_PRE_IDX = 8'h20; // Preload entry index.
    localparam logic [7:0] OFS_PRE_DATA = 8'h24; // Preload descriptor.

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int CFG_REF_BIT = 0; // Referenced bit update enable.
    localparam int CFG_MOD_BIT = 1; // Modified bit update enable.
    localparam int DSC_PRESENT = 0; // Descriptor present.
    localparam int DSC_REF = 1; // Descriptor referenced.
    localparam int DSC_MOD = 2; // Descriptor modified.
    localparam int DSC_CACHE = 3; // Segment is cacheable.
    localparam int DSC_OBJ_TRAP = 4; // Every access traps.
    localparam int DSC_WR_FAULT = 5; // Writes raise a page-write fault.
    localparam int DSC_BASE_LSB = 8; // Base field starts here.
    localparam int VA_OFS_W = 24; // Segment offset width.
    localparam int EV_FAULT = 0; // Event bit: fault raised, whether or not it is captured.
    localparam int EV_FILL = 1; // Event bit: cache filled by miss.
    localparam int EV_FLUSH = 2; // Event bit: caches flushed.
    localparam int EV_W = 3; // Number of event bits.

    // ****************************************************************
    // Reset values.
    // ****************************************************************
    localparam logic [1:0] CONFIG_RST = 2'h0;
    localparam logic [31:0] SEG_BASE_RST = 32'h0000_0000;
    localparam logic [7:0] SEG_LEN_RST = 8'h00;
    localparam logic [7:0] FCODE_RST = 8'h00;

    // ****************************************************************
    // Fault codes held in the fault code register.
    // ****************************************************************
    localparam logic [7:0] FC_NONE = 8'h00;
    localparam logic [7:0] FC_NOT_PRESENT = 8'h01;
    localparam logic [7:0] FC_LENGTH = 8'h02;
    localparam logic [7:0] FC_OBJ_TRAP = 8'h03;
    localparam logic [7:0] FC_PAGE_WRITE = 8'h04;
    localparam logic [7:0] FC_MEM = 8'h05;

    // Translation sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CHECK,
        ST_FETCH,
        ST_UPDATE,
        ST_DONE
    } msf_state_t;

endpackage

// file: rtl/msf_pin_sync.sv
`timescale 1ns/1ps

// ********************************************************************
// Three-stage pin synchroniser with agreement filter.
// ********************************************************************
module msf_pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);

    logic [WIDTH-1:0] s1_reg;  // First stage, read only by the second.
    logic [WIDTH-1:0] s2_reg;  // Second stage.
    logic [WIDTH-1:0] s3_reg;  // Third stage.

    // Shift the pins through three flip-flops.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A change counts once the second and third stages agree.
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    level[gi] <= 1'b0;
                end else if (s2_reg[gi] == s3_reg[gi]) begin
                    level[gi] <= s3_reg[gi];
                end
            end
        end
    endgenerate

endmodule

// file: tb/msf_props.sv
`timescale 1ns/1ps

// ****************************************
// Port checks on the translation unit.
// ****************************************
module msf_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic xlate_select_a,
    input wire logic xlate_select_b,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic xl_done,
    input wire logic xl_out_oe_n,
    input wire logic xlate_fault_out,
    input wire logic xlate_fault_oe_n,
    input wire logic desc_req,
    input wire logic desc_wr,
    input wire logic [31:0] desc_addr,
    input wire logic desc_ack
);
    // Every check runs on the one clock and stops in reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_oe_pair: assert property (xl_out_oe_n == xlate_fault_oe_n)
        else $error("output enables disagree");
    chk_sel_on: assert property (
        (xlate_select_a && xlate_select_b) [*8] |-> !xl_out_oe_n)
        else $error("selected unit does not drive");
    chk_sel_off: assert property (
        (!xlate_select_a && !xlate_select_b) [*8] |-> xl_out_oe_n)
        else $error("unselected unit still drives");
    chk_unsel_quiet: assert property (
        !(xlate_select_a && xlate_select_b) [*8] |-> !xl_done && !desc_req)
        else $error("inactive unit translates");
    chk_unsel_rd: assert property (
        !(xlate_select_a && xlate_select_b) [*8] |-> reg_rdata == 32'h0)
        else $error("inactive unit answers a read");
    chk_fault_done: assert property (xlate_fault_out |-> ##[1:2] xl_done)
        else $error("fault without finish");
    chk_rd_gap: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    chk_done_pulse: assert property (xl_done |=> !xl_done)
        else $error("finish longer than a cycle");
    chk_desc_hold: assert property (
        desc_req && !desc_ack |=> desc_req && $stable(desc_addr)
        && $stable(desc_wr))
        else $error("descriptor request changed before answer");
endmodule

// file: tb/msf_mem.sv
`timescale 1ns/1ps

// ****************************************
// Descriptor memory beside the unit.
// ****************************************
module msf_mem (
    input wire logic clk,
    input wire logic nrst,
    input wire logic desc_req,
    input wire logic desc_wr,
    input wire logic [31:0] desc_addr,
    input wire logic [31:0] desc_wdata,
    input wire logic [3:0] lat,
    input wire logic err_on,
    output logic desc_ack,
    output logic [31:0] desc_rdata,
    output logic desc_err
);
    logic [31:0] mem [0:7]; // Descriptor words, table base is zero.
    logic [3:0] wait_cnt; // Cycles the current request has waited.

    // Answer after lat cycles; idle data toggles so stale reads show.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_cnt <= 4'h0;
            desc_ack <= 1'b0;
            desc_err <= 1'b0;
            desc_rdata <= 32'h0;
        end else if (desc_req && !desc_ack && wait_cnt >= lat) begin
            desc_ack <= 1'b1;
            desc_err <= err_on;
            desc_rdata <= mem[desc_addr[4:2]];
            if (desc_wr) mem[desc_addr[4:2]] <= desc_wdata;
            wait_cnt <= 4'h0;
        end else begin
            desc_ack <= 1'b0;
            desc_err <= 1'b0;
            desc_rdata <= ~desc_rdata;
            wait_cnt <= (desc_req && !desc_ack) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// file: tb/test_msf_top.sv
`timescale 1ns/1ps

// ****************************************
// Register and translation tests.
// ****************************************
module test_msf_top import msf_pkg::*; ;
    logic clk, nrst, xlate_select_a, xlate_select_b, err_on, flt;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, xl_vaddr, xl_paddr;
    logic reg_wr, reg_rd, xl_req, xl_write, xl_done, xl_cacheable, irq;
    logic xl_out_oe_n, xlate_fault_out, xlate_fault_oe_n;
    logic desc_req, desc_wr, desc_ack, desc_err;
    logic [31:0] desc_addr, desc_wdata, desc_rdata;
    logic [3:0] lat;
    int errors = 0, check_count = 0, cycles = 0;
    // Fault cases: address, descriptor preloaded for the first three, expected code.
    localparam logic [31:0] FVA [4] = '{32'h0300_0008, 32'h0400_0004,
        32'h0500_0000, 32'h0700_0000};
    localparam logic [31:0] FDS [4] = '{32'h0, 32'h11, 32'h21, 32'h1};
    localparam logic [7:0] FCS [4] = '{FC_NOT_PRESENT, FC_OBJ_TRAP,
        FC_PAGE_WRITE, FC_LENGTH};

    msf_top msf_top_i (.*);
    msf_mem msf_mem_i (.*);

    // Clock at 40 MHz and a cycle ceiling against hangs.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    // Read data is looked at only in the cycle after the strobe.
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, e);
        @(posedge clk);
    endtask
    // One translation; flt tells whether a fault pulse was seen.
    task automatic xlate(input logic [31:0] va, input logic w);
        int n;
        flt = 1'b0;
        n = 0;
        xl_vaddr <= va;
        xl_write <= w;
        xl_req <= 1'b1;
        @(posedge clk);
        xl_req <= 1'b0;
        while (xl_done !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            if (xlate_fault_out === 1'b1) flt = 1'b1;
            n++;
        end
        check(n < 60, xlate_select_a & xlate_select_b);
        @(posedge clk);
    endtask

    initial begin
        {nrst, reg_wr, reg_rd, xl_req, xl_write, err_on} = 6'h0;
        // Lone unit: both selects held high until the select tests at the end.
        {xlate_select_a, xlate_select_b} = 2'h3;
        {reg_addr, reg_wdata, xl_vaddr, lat} = 76'h0;
        // Bases stay far below the top of memory.
        msf_mem_i.mem[1] = 32'h0001_2309;
        msf_mem_i.mem[2] = 32'h0;
        msf_mem_i.mem[6] = 32'h0007_0001;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        rdc(OFS_CONFIG, 32'h0);
        rdc(OFS_FCODE, 32'h0);
        rdc(8'h30, 32'h0);
        wr(OFS_SEG_BASE, 32'h0);
        wr(OFS_SEG_LEN, 32'h7);
        wr(OFS_IRQ_EN, 32'h7);
        rdc(OFS_SEG_LEN, 32'h7);
        rdc(OFS_IRQ_STAT, 32'h4);
        check(irq, 1'b1);
        wr(OFS_IRQ_CLR, 32'h7);
        check(irq, 1'b0);
        xlate(32'h0100_0044, 1'b0);
        check(xl_paddr, 32'h0001_2344);
        check(xl_cacheable, 1'b1);
        rdc(OFS_IRQ_STAT, 32'h2);
        msf_mem_i.mem[1] = 32'h0009_9301;
        wr(OFS_SEG_BASE, 32'h0);
        xlate(32'h0100_0044, 1'b0);
        check(xl_paddr, 32'h0009_9344);
        wr(OFS_PRE_IDX, 32'h2);
        wr(OFS_PRE_DATA, 32'h0005_0001);
        xlate(32'h0200_0010, 1'b0);
        check(xl_paddr, 32'h0005_0010);
        check({flt, xl_cacheable}, 2'h0);
        $display("test done: fill, flush and preload");
        for (int i = 0; i < 4; i++) begin
            if (i < 3) begin
                wr(OFS_PRE_IDX, {29'h0, FVA[i][26:24]});
                wr(OFS_PRE_DATA, FDS[i]);
            end
            xlate(FVA[i], i == 2);
            check(flt, 1'b1);
            rdc(OFS_FADDR, FVA[i]);
            rdc(OFS_FCODE, {24'h0, FCS[i]});
        end
        xlate(FVA[1], 1'b0);
        xlate(FVA[0], 1'b0);
        rdc(OFS_FADDR, FVA[1]);
        rdc(OFS_FCODE, {24'h0, FC_OBJ_TRAP});
        $display("test done: fault capture");
        wr(OFS_CONFIG, 32'h3);
        lat <= 4'h3;
        xlate(32'h0600_0020, 1'b1);
        check(msf_mem_i.mem[6], 32'h0007_0007);
        check(xl_paddr, 32'h0007_0020);
        err_on <= 1'b1;
        wr(OFS_SEG_BASE, 32'h0);
        xlate(32'h0000_0000, 1'b0);
        rdc(OFS_FCODE, {24'h0, FC_MEM});
        err_on <= 1'b0;
        $display("test done: bit update and memory error");
        xlate_select_b <= 1'b0;
        repeat (8) @(posedge clk);
        rdc(OFS_CONFIG, 32'h0);
        xlate(32'h0100_0044, 1'b0);
        check(xl_out_oe_n, 1'b0);
        xlate_select_a <= 1'b0;
        repeat (8) @(posedge clk);
        check({xl_out_oe_n, xlate_fault_oe_n}, 2'h3);
        {xlate_select_a, xlate_select_b} <= 2'h3;
        repeat (8) @(posedge clk);
        rdc(OFS_CONFIG, 32'h3);
        $display("test done: selects");
        results();
    end
endmodule

bind msf_top msf_props msf_props_i (.*);
